// [hw/asr_serial.v]
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ns
`include "asr_regs.vh"
module asr_serial (
  // Clock and reset.
  input wire i_sys_clk,
  input wire i_rst,
  // AXI4-Lite write address.
  input wire [7:0] i_awaddr,
  input wire i_awvalid,
  output wire o_awready,
  // AXI4-Lite write data.
  input wire [31:0] i_wdata,
  input wire [3:0] i_wstrb,
  input wire i_wvalid,
  output wire o_wready,
  // AXI4-Lite write response.
  output reg [1:0] o_bresp,
  output reg o_bvalid,
  input wire i_bready,
  // AXI4-Lite read address.
  input wire [7:0] i_araddr,
  input wire i_arvalid,
  output wire o_arready,
  // AXI4-Lite read data.
  output reg [31:0] o_rdata,
  output reg [1:0] o_rresp,
  output reg o_rvalid,
  input wire i_rready,
  // Serial lines.
  input wire i_rx,
  output reg o_tx,
  // Interrupt request.
  output wire o_irq
);
  reg [7:0] ctrl;
  reg [15:0] baud;
  reg [3:0] irqen;
  reg aw_hold;
  reg [7:0] aw_addr;
  reg w_hold;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  wire port_en = ctrl[`ASR_CTL_PORT_EN];
  wire tx_en = ctrl[`ASR_CTL_TX_EN];
  wire rx_en = ctrl[`ASR_CTL_RX_EN];
  // Baud divider producing a sixteen-times tick.
  reg [15:0] div_cnt;
  wire os_tick = (div_cnt == baud);
  // Transmit path.
  reg [8:0] hold_data;
  reg hold_full;
  reg [9:0] tx_shift_reg;
  reg tx_busy;
  reg [3:0] tx_os;
  reg [3:0] tx_bits;
  reg [1:0] rdy_dly;
  wire tx_last_bit = ctrl[`ASR_CTL_TX_NINTH_BIT] | !ctrl[`ASR_CTL_TX9];
  // Receive path.
  reg rx_s1;
  reg rx_s2;
  reg rx_prev;
  reg [1:0] rx_state;
  reg [3:0] rx_os;
  reg [3:0] rx_bits;
  reg [8:0] rx_shift_reg;
  reg [2:0] vote;
  reg [9:0] fifo_mem [0:1];
  reg rd_ptr;
  reg wr_ptr;
  reg [1:0] fifo_cnt;
  reg overrun;
  localparam RX_HUNT = 2'd0;
  localparam RX_START = 2'd1;
  localparam RX_DATA = 2'd2;
  localparam RX_STOP = 2'd3;
  function maj3;
    input [2:0] v;
    begin
      maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    end
  endfunction
  // Bus handshake.
  assign o_awready = !aw_hold && !o_bvalid;
  assign o_wready = !w_hold && !o_bvalid;
  assign o_arready = !o_rvalid;
  wire wr_go = aw_hold && w_hold && !o_bvalid;
  wire rd_go = i_arvalid && o_arready;
  wire wr_tx = wr_go && (aw_addr == `ASR_TXDATA_ADDR) && w_strb[0];
  wire rd_rx = rd_go && (i_araddr == `ASR_RXDATA_ADDR);
  wire rx_avail = rx_en && (fifo_cnt != 2'd0);
  wire [9:0] fifo_top = fifo_mem[rd_ptr];
  wire tx_ready = tx_en && (!hold_full || rdy_dly != 2'd0);
  wire [7:0] status = {1'b0, o_irq, fifo_top[8], overrun, fifo_top[9] & (fifo_cnt != 2'd0),
                       rx_avail, !tx_busy, tx_ready};
  assign o_irq = irqen[`ASR_IE_GLOBAL] && irqen[`ASR_IE_PERIPH] &&
                 ((irqen[`ASR_IE_TX] && tx_ready) || (irqen[`ASR_IE_RX] && rx_avail));
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      aw_hold <= 1'b0;
      aw_addr <= 8'h00;
      w_hold <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      o_bvalid <= 1'b0;
      o_bresp <= `ASR_RESP_OKAY;
      o_rvalid <= 1'b0;
      o_rresp <= `ASR_RESP_OKAY;
      o_rdata <= 32'h0000_0000;
      ctrl <= `ASR_CTL_RESET;
      baud <= `ASR_BAUD_RESET;
      irqen <= 4'h0;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_hold <= 1'b1;
        aw_addr <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        w_hold <= 1'b1;
        w_data <= i_wdata;
        w_strb <= i_wstrb;
      end
      if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
      if (wr_go) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp <= `ASR_RESP_OKAY;
        case (aw_addr)
          `ASR_CTRL_ADDR: begin
            if (w_strb[0]) begin
              ctrl <= w_data[7:0];
            end
          end
          `ASR_BAUD_ADDR: begin
            if (w_strb[0]) begin
              baud[7:0] <= w_data[7:0];
            end
            if (w_strb[1]) begin
              baud[15:8] <= w_data[15:8];
            end
          end
          `ASR_IRQEN_ADDR: begin
            if (w_strb[0]) begin
              irqen <= w_data[3:0];
            end
          end
          `ASR_TXDATA_ADDR: begin
          end
          `ASR_STATUS_ADDR: begin
          end
          `ASR_RXDATA_ADDR: begin
          end
          default: begin
            o_bresp <= `ASR_RESP_SLVERR;
          end
        endcase
      end
      if (o_rvalid && i_rready) begin
        o_rvalid <= 1'b0;
      end
      if (rd_go) begin
        o_rvalid <= 1'b1;
        o_rresp <= `ASR_RESP_OKAY;
        case (i_araddr)
          `ASR_CTRL_ADDR: o_rdata <= {24'h00_0000, ctrl};
          `ASR_STATUS_ADDR: o_rdata <= {24'h00_0000, status};
          `ASR_RXDATA_ADDR: o_rdata <= {24'h00_0000, fifo_top[7:0]};
          `ASR_BAUD_ADDR: o_rdata <= {16'h0000, baud};
          `ASR_IRQEN_ADDR: o_rdata <= {28'h000_0000, irqen};
          `ASR_TXDATA_ADDR: o_rdata <= 32'h0000_0000;
          default: begin
            o_rdata <= 32'h0000_0000;
            o_rresp <= `ASR_RESP_SLVERR;
          end
        endcase
      end
    end
  end
  // Baud divider, restarted on a divisor write.
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      div_cnt <= 16'h0000;
    end else if (!port_en || os_tick || (wr_go && aw_addr == `ASR_BAUD_ADDR)) begin
      div_cnt <= 16'h0000;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
    end
  end
  // Transmitter.
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      hold_data <= 9'h000;
      hold_full <= 1'b0;
      tx_shift_reg <= 10'h3FF;
      tx_busy <= 1'b0;
      tx_os <= 4'h0;
      tx_bits <= 4'h0;
      rdy_dly <= 2'd0;
      o_tx <= 1'b1;
    end else if (!port_en) begin
      hold_full <= 1'b0;
      tx_busy <= 1'b0;
      rdy_dly <= 2'd0;
      o_tx <= !ctrl[`ASR_CTL_TX_INV];
    end else begin
      o_tx <= (tx_busy ? tx_shift_reg[0] : 1'b1) ^ ctrl[`ASR_CTL_TX_INV];
      if (rdy_dly != 2'd0) begin
        rdy_dly <= rdy_dly - 2'd1;
      end
      if (wr_tx && tx_busy) begin
        hold_data <= {tx_last_bit, w_data[7:0]};
        hold_full <= 1'b1;
      end
      if (wr_tx && tx_busy && !hold_full) begin
        rdy_dly <= `ASR_TXRDY_DELAY;
      end
      if (!tx_busy && (wr_tx || hold_full)) begin
        tx_shift_reg <= wr_tx ? {tx_last_bit, w_data[7:0], 1'b0}
                     : {hold_data, 1'b0};
        hold_full <= 1'b0;
        tx_busy <= 1'b1;
        tx_os <= 4'h0;
        tx_bits <= ctrl[`ASR_CTL_TX9] ? 4'd10 : 4'd9;
      end else if (tx_busy && os_tick) begin
        tx_os <= tx_os + 4'h1;
        if (tx_os == 4'hF) begin
          tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
          if (tx_bits == 4'd0) begin
            tx_busy <= 1'b0;
          end else begin
            tx_bits <= tx_bits - 4'd1;
          end
        end
      end
    end
  end
  // Receive line synchroniser.
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
      rx_prev <= 1'b1;
    end else begin
      rx_s1 <= i_rx;
      rx_s2 <= rx_s1;
      rx_prev <= rx_s2;
    end
  end
  // Receiver.
  wire rx_bit = maj3({vote[1:0], rx_s2});
  wire [8:0] rx_char = ctrl[`ASR_CTL_RX9] ? rx_shift_reg : {1'b0, rx_shift_reg[8:1]};
  wire rx_keep = !(ctrl[`ASR_CTL_ADDR_DET] && ctrl[`ASR_CTL_RX9] && !rx_char[8]);
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      rx_state <= RX_HUNT;
      rx_os <= 4'h0;
      rx_bits <= 4'h0;
      rx_shift_reg <= 9'h000;
      vote <= 3'b111;
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
      fifo_cnt <= 2'd0;
      overrun <= 1'b0;
      fifo_mem[0] <= 10'h000;
      fifo_mem[1] <= 10'h000;
    end else if (!port_en) begin
      rx_state <= RX_HUNT;
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
      fifo_cnt <= 2'd0;
      overrun <= 1'b0;
    end else begin
      if (!rx_en) begin
        overrun <= 1'b0;
      end
      if (rd_rx && fifo_cnt != 2'd0) begin
        rd_ptr <= !rd_ptr;
      end
      if (os_tick) begin
        vote <= {vote[1:0], rx_s2};
      end
      case (rx_state)
        RX_HUNT: begin
          if (rx_en && !overrun && rx_prev && !rx_s2) begin
            rx_state <= RX_START;
            rx_os <= 4'h0;
          end
        end
        RX_START: begin
          if (os_tick) begin
            rx_os <= rx_os + 4'h1;
            if (rx_os == 4'd7) begin
              rx_os <= 4'h0;
              rx_bits <= ctrl[`ASR_CTL_RX9] ? 4'd9 : 4'd8;
              rx_state <= rx_bit ? RX_HUNT : RX_DATA;
            end
          end
        end
        RX_DATA: begin
          if (os_tick) begin
            rx_os <= rx_os + 4'h1;
            if (rx_os == 4'hF) begin
              rx_shift_reg <= {rx_bit, rx_shift_reg[8:1]};
              rx_bits <= rx_bits - 4'd1;
              if (rx_bits == 4'd1) begin
                rx_state <= RX_STOP;
              end
            end
          end
        end
        RX_STOP: begin
          if (os_tick) begin
            rx_os <= rx_os + 4'h1;
            if (rx_os == 4'hF) begin
              rx_state <= RX_HUNT;
              if (rx_keep && rx_en) begin
                if (fifo_cnt == 2'd2 && !(rd_rx)) begin
                  overrun <= 1'b1;
                end else begin
                  fifo_mem[wr_ptr] <= {!rx_bit, rx_char};
                  wr_ptr <= !wr_ptr;
                end
              end
            end
          end
        end
        default: rx_state <= RX_HUNT;
      endcase
      // Buffer occupancy follows pushes and pops together.
      if (rx_state == RX_STOP && os_tick && rx_os == 4'hF && rx_keep && rx_en &&
          (fifo_cnt != 2'd2 || rd_rx)) begin
        if (!(rd_rx && fifo_cnt != 2'd0)) begin
          fifo_cnt <= fifo_cnt + 2'd1;
        end
      end else if (rd_rx && fifo_cnt != 2'd0) begin
        fifo_cnt <= fifo_cnt - 2'd1;
      end
    end
  end
endmodule // asr_serial

// [common/asr_regs.vh]
`ifndef ASR_REGS_VH
`define ASR_REGS_VH
// Register byte offsets.
`define ASR_CTRL_ADDR 8'h00
`define ASR_STATUS_ADDR 8'h04
`define ASR_TXDATA_ADDR 8'h08
`define ASR_RXDATA_ADDR 8'h0C
`define ASR_BAUD_ADDR 8'h10
`define ASR_IRQEN_ADDR 8'h14
// Control field positions.
`define ASR_CTL_PORT_EN 0
`define ASR_CTL_TX_EN 1
`define ASR_CTL_RX_EN 2
`define ASR_CTL_TX9 3
`define ASR_CTL_RX9 4
`define ASR_CTL_ADDR_DET 5
`define ASR_CTL_TX_INV 6
`define ASR_CTL_TX_NINTH_BIT 7
`define ASR_CTL_WIDTH 8
`define ASR_CTL_RESET 8'h00
// Status field positions.
`define ASR_ST_TX_READY 0
`define ASR_ST_SHIFT_EMPTY 1
`define ASR_ST_RX_AVAIL 2
`define ASR_ST_FRAME_ERR 3
`define ASR_ST_OVERRUN 4
`define ASR_ST_RX_NINTH_BIT 5
`define ASR_ST_IRQ 6
// Interrupt enable field positions.
`define ASR_IE_TX 0
`define ASR_IE_RX 1
`define ASR_IE_PERIPH 2
`define ASR_IE_GLOBAL 3
// Baud divisor reset value and oversampling factor.
`define ASR_BAUD_RESET 16'h0000
`define ASR_OVERSAMPLE 16
// System clock cycle delay before the ready flag reflects a write.
`define ASR_TXRDY_DELAY 2'h2
// AXI responses.
`define ASR_RESP_OKAY 2'b00
`define ASR_RESP_SLVERR 2'b10
`endif

// [sim/asr_checker.sv]
`timescale 1ns/1ns
`include "asr_regs.vh"
module asr_checker (
  input wire i_sys_clk,
  input wire i_rst,
  input wire [7:0] i_awaddr,
  input wire i_awvalid,
  input wire o_awready,
  input wire [31:0] i_wdata,
  input wire i_wvalid,
  input wire o_wready,
  input wire [1:0] o_bresp,
  input wire o_bvalid,
  input wire i_bready,
  input wire [7:0] i_araddr,
  input wire i_arvalid,
  input wire o_arready,
  input wire [31:0] o_rdata,
  input wire [1:0] o_rresp,
  input wire o_rvalid,
  input wire i_rready,
  input wire o_tx,
  input wire o_irq
);
  reg [7:0] aw_q;
  reg [7:0] ar_q;
  reg [7:0] w_q;
  reg [3:0] ie_q;
  reg bv_d;
  // Shadow of the last write and of the last read address so that effects can be tied to them.
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      aw_q <= 8'h00;
      ar_q <= 8'h00;
      w_q <= 8'h00;
      ie_q <= 4'h0;
      bv_d <= 1'b0;
    end else begin
      bv_d <= o_bvalid;
      if (i_awvalid && o_awready) aw_q <= i_awaddr;
      if (i_arvalid && o_arready) ar_q <= i_araddr;
      if (i_wvalid && o_wready) w_q <= i_wdata[7:0];
      if (o_bvalid && !bv_d && aw_q == `ASR_IRQEN_ADDR) ie_q <= w_q[3:0];
    end
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  property p_bhold;
    o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped early");
  property p_rhold;
    o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped early");
  property p_rans;
    i_arvalid && o_arready |=> o_rvalid;
  endproperty
  a_rans: assert property (p_rans) else $error("read answer late");
  property p_arblk;
    o_rvalid |-> !o_arready;
  endproperty
  a_arblk: assert property (p_arblk) else $error("read address taken while busy");
  property p_awblk;
    o_bvalid |-> !o_awready;
  endproperty
  a_awblk: assert property (p_awblk) else $error("write address taken while busy");
  property p_unmap;
    $rose(o_rvalid) && ar_q > `ASR_IRQEN_ADDR |-> o_rresp == `ASR_RESP_SLVERR && o_rdata == 0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not refused");
  property p_bit;
    $changed(o_tx) && !o_bvalid |=> ($stable(o_tx) || o_bvalid)[*6];
  endproperty
  a_bit: assert property (p_bit) else $error("serial bit too short");
  property p_off;
    $rose(o_bvalid) && aw_q == `ASR_CTRL_ADDR && w_q[0] == 1'b0 && w_q[6] == 1'b0
      |-> ##[0:2] o_tx;
  endproperty
  a_off: assert property (p_off) else $error("line not idle after disable");
  property p_irq;
    !ie_q[`ASR_IE_GLOBAL] && !$rose(o_bvalid) |-> !o_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt without global enable");
endmodule // asr_checker
bind asr_serial asr_checker chk (.i_sys_clk, .i_rst, .i_awaddr, .i_awvalid, .o_awready,
  .i_wdata, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid,
  .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .o_tx, .o_irq);

// [sim/asr_peer.sv]
`timescale 1ns/1ns
module asr_peer #(parameter int BIT = 16) (
  input wire i_sys_clk,
  input wire i_tx,
  output logic o_rx
);
  initial o_rx = 1'b1;
  // Sends one frame: start, data least significant first, stop level s.
  task automatic send(input [8:0] d, input int nb, input s);
    o_rx <= 1'b0;
    repeat (BIT) @(posedge i_sys_clk);
    for (int i = 0; i < nb; i++) begin
      o_rx <= d[i];
      repeat (BIT) @(posedge i_sys_clk);
    end
    o_rx <= s;
    repeat (BIT) @(posedge i_sys_clk);
    o_rx <= 1'b1;
    repeat (BIT) @(posedge i_sys_clk);
  endtask
  // A start pulse shorter than half a bit.
  task automatic glitch;
    o_rx <= 1'b0;
    repeat (BIT / 4) @(posedge i_sys_clk);
    o_rx <= 1'b1;
    repeat (11 * BIT) @(posedge i_sys_clk);
  endtask
  // Samples one frame at bit centres.
  task automatic recv(output [8:0] d, output s, input int nb);
    d = 9'h000;
    @(negedge i_tx);
    repeat (BIT / 2) @(posedge i_sys_clk);
    for (int i = 0; i < nb; i++) begin
      repeat (BIT) @(posedge i_sys_clk);
      d[i] = i_tx;
    end
    repeat (BIT) @(posedge i_sys_clk);
    s = i_tx;
  endtask
endmodule // asr_peer

// [sim/test_async_serial_txrx_status.sv]
`timescale 1ns/1ns
`include "asr_regs.vh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fail_count++; $display("MISMATCH %0t got %0h expected %0h", $time, (a), (b)); end end
module test_async_serial_txrx_status;
  logic clk = 0;
  logic rst = 1;
  logic [7:0] awa = 0;
  logic [7:0] ara = 0;
  logic [31:0] wd = 0;
  logic awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  wire awr, wrd, bv, arr, rv, rx, tx, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  logic [31:0] d;
  logic [1:0] r;
  logic [8:0] c;
  logic s;
  int fail_count = 0, num_checks = 0;
  logic [7:0] rows [4][2] = '{'{8'h00, 8'h00}, '{8'hFF, 8'hFF}, '{8'hA5, 8'hA5}, '{8'h3C, 8'h3C}};
  asr_serial dut (.i_sys_clk(clk), .i_rst(rst), .i_awaddr(awa), .i_awvalid(awv),
    .o_awready(awr), .i_wdata(wd), .i_wstrb(4'hF), .i_wvalid(wv), .o_wready(wrd),
    .o_bresp(bresp), .o_bvalid(bv), .i_bready(br), .i_araddr(ara), .i_arvalid(arv),
    .o_arready(arr), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rv), .i_rready(rr),
    .i_rx(rx), .o_tx(tx), .o_irq(irq));
  asr_peer #(.BIT(`ASR_OVERSAMPLE)) p (.i_sys_clk(clk), .i_tx(tx), .o_rx(rx));
  task wr(input [7:0] a, input [31:0] v);
    @(posedge clk);
    awa <= a;
    wd <= v;
    awv <= 1;
    wv <= 1;
    br <= 1;
    do begin
      @(posedge clk);
      if (awr) awv <= 0;
      if (wrd) wv <= 0;
    end while (bv !== 1'b1);
    br <= 0;
  endtask
  task rd(input [7:0] a);
    @(posedge clk);
    ara <= a;
    arv <= 1;
    rr <= 1;
    do begin
      @(posedge clk);
      if (arr) arv <= 0;
    end while (rv !== 1'b1);
    d = rdata;
    r = rresp;
    rr <= 0;
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial forever #20 clk = ~clk;
  initial begin
    repeat (30000) @(posedge clk);
    fail_count++;
    wrap_up();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 0;
    rd(`ASR_STATUS_ADDR);
    `CHK(d, 32'h0000_0002)
    rd(8'h40);
    `CHK(r, `ASR_RESP_SLVERR)
    wr(`ASR_BAUD_ADDR, 32'h0000_0000);
    wr(`ASR_CTRL_ADDR, 32'h0000_0007);
    rd(`ASR_STATUS_ADDR);
    `CHK(d[1:0], 2'b11)
    for (int i = 0; i < 4; i++) begin
      fork
        wr(`ASR_TXDATA_ADDR, {24'h00_0000, rows[i][0]});
        p.recv(c, s, 8);
      join
      `CHK(c[7:0], rows[i][1])
      `CHK(c[8], 1'b0)
      `CHK(s, 1'b1)
      p.send({1'b0, rows[i][0]}, 8, 1'b1);
      rd(`ASR_STATUS_ADDR);
      `CHK(d[`ASR_ST_RX_AVAIL], 1'b1)
      rd(`ASR_RXDATA_ADDR);
      `CHK(d[7:0], rows[i][1])
    end
    fork
      begin
        wr(`ASR_TXDATA_ADDR, 32'h0000_0031);
        wr(`ASR_TXDATA_ADDR, 32'h0000_0032);
        rd(`ASR_STATUS_ADDR);
        `CHK(d[`ASR_ST_SHIFT_EMPTY], 1'b0)
        `CHK(d[`ASR_ST_TX_READY], 1'b0)
      end
      begin
        p.recv(c, s, 8);
        `CHK(c, 9'h031)
        p.recv(c, s, 8);
        `CHK(c, 9'h032)
      end
    join
    wr(`ASR_CTRL_ADDR, 32'h0000_008F);
    fork
      wr(`ASR_TXDATA_ADDR, 32'h0000_005A);
      p.recv(c, s, 9);
    join
    `CHK(c, 9'h15A)
    wr(`ASR_CTRL_ADDR, 32'h0000_0007);
    p.send(9'h011, 8, 1'b0);
    p.send(9'h022, 8, 1'b1);
    p.send(9'h033, 8, 1'b1);
    rd(`ASR_STATUS_ADDR);
    `CHK(d[4:2], 3'b111)
    rd(`ASR_RXDATA_ADDR);
    `CHK(d[7:0], 8'h11)
    rd(`ASR_STATUS_ADDR);
    `CHK(d[`ASR_ST_FRAME_ERR], 1'b0)
    rd(`ASR_RXDATA_ADDR);
    `CHK(d[7:0], 8'h22)
    wr(`ASR_CTRL_ADDR, 32'h0000_0003);
    rd(`ASR_STATUS_ADDR);
    `CHK(d[`ASR_ST_OVERRUN], 1'b0)
    wr(`ASR_CTRL_ADDR, 32'h0000_0007);
    p.glitch();
    rd(`ASR_STATUS_ADDR);
    `CHK(d[`ASR_ST_RX_AVAIL], 1'b0)
    wr(`ASR_CTRL_ADDR, 32'h0000_0037);
    p.send(9'h033, 9, 1'b1);
    p.send(9'h1A5, 9, 1'b1);
    wr(`ASR_IRQEN_ADDR, 32'h0000_000E);
    rd(`ASR_STATUS_ADDR);
    `CHK(d[`ASR_ST_RX_NINTH_BIT], 1'b1)
    `CHK(irq, 1'b1)
    wr(`ASR_IRQEN_ADDR, 32'h0000_0006);
    `CHK(irq, 1'b0)
    rd(`ASR_RXDATA_ADDR);
    `CHK(d[7:0], 8'hA5)
    wr(`ASR_CTRL_ADDR, 32'h0000_0007);
    wr(`ASR_TXDATA_ADDR, 32'h0000_0000);
    repeat (40) @(posedge clk);
    wr(`ASR_CTRL_ADDR, 32'h0000_0000);
    repeat (8) @(posedge clk);
    `CHK(tx, 1'b1)
    rd(`ASR_STATUS_ADDR);
    `CHK(d[`ASR_ST_SHIFT_EMPTY], 1'b1)
    wr(`ASR_CTRL_ADDR, 32'h0000_0043);
    repeat (8) @(posedge clk);
    `CHK(tx, 1'b0)
    wr(`ASR_CTRL_ADDR, 32'h0000_0000);
    repeat (8) @(posedge clk);
    `CHK(tx, 1'b1)
    wrap_up();
  end
endmodule // test_async_serial_txrx_status
